// ### src/exc_ctrl_regs.vh
/*
 * register map, table positions, priority keys and state codes of the
 * top-level exception controller.
 * assumes a 12-bit APB byte address window and the 250 MHz system clock.
 */
`ifndef EXC_CTRL_REGS_VH
`define EXC_CTRL_REGS_VH

// table layout
`define EXC_COUNT        33
`define EXC_LAST         32
`define EXC_SLOTS        6'h21
`define POS_W            6
`define POS_SP           6'h00
`define POS_RESET        6'h01
`define POS_NMI          2
`define POS_HARD         3
`define POS_MEM          4
`define POS_BUS          5
`define POS_USAGE        6
`define POS_SVC          11
`define POS_DBGMON       12
`define POS_PENDABLE_SERVICE_REQUEST       14
`define POS_SYSTEM_TICK_EXCEPTION      15
`define IRQ_BASE         16
`define IRQ_COUNT        17
`define IRQ_TOP          16

// slots that hold a pend latch, and slots whose priority software sets
`define PEND_IMPL_MASK   33'h1_ffff_d878
`define PRI_CFG_MASK     33'h1_ffff_d870

// priority keys: lower wins; configurable levels sit above the fixed ones
`define PRI_W            5
`define KEY_W            6
`define KEY_NMI          6'h00
`define KEY_HARD         6'h01
`define KEY_BIAS         6'h02
`define KEY_IDLE         6'h3f

// register byte offsets
`define OFF_EN_SET       12'h000
`define OFF_EN_CLR       12'h004
`define OFF_PEND_SET     12'h008
`define OFF_PEND_CLR     12'h00c
`define OFF_ACTIVE       12'h010
`define OFF_SYS_CTRL     12'h014
`define OFF_CUR_PRI      12'h018
`define REGION_PRI       4'h1
`define REGION_VEC       4'h2

// system control register fields
`define CTL_MEM_EN       0
`define CTL_BUS_EN       1
`define CTL_USAGE_EN     2
`define CTL_DBGMON_EN    3
`define CTL_PENDABLE_SERVICE_REQUEST_SET   4
`define CTL_PENDABLE_SERVICE_REQUEST_CLR   5
`define CTL_W            4
`define CTL_RESET        4'h0

// reset sequencer, one-hot
`define ST_SP            3'h1
`define ST_RV            3'h2
`define ST_RUN           3'h4

`endif

// ### src/exc_priority_select.v
/*
 * picks the winning entry among requesting table slots: lowest key wins,
 * on equal keys the lowest slot position wins.
 * assumes keys are packed slot 0 in the low bits; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
`include "exc_ctrl_regs.vh"

module exc_priority_select
(
   input  wire [`EXC_COUNT-1:0]        req,
   input  wire [`EXC_COUNT*`KEY_W-1:0] keys,
   output reg                          found,
   output reg  [`POS_W-1:0]            idx,
   output reg  [`KEY_W-1:0]            key
);

   integer i;

   // ascending scan with strict compare keeps the lower position on ties
   always @*
   begin
      found = 1'b0;
      idx   = `POS_SP;
      key   = `KEY_IDLE;
      for (i = 0; i < `EXC_COUNT; i = i + 1)
      begin
         if (req[i] && (!found || keys[i*`KEY_W +: `KEY_W] < key))
         begin
            found = 1'b1;
            idx   = i[`POS_W-1:0];
            key   = keys[i*`KEY_W +: `KEY_W];
         end
      end
   end

endmodule
`default_nettype wire

// ### src/top_level_exception_controller.v
/*
 * top-level exception controller: vector table, priority resolution,
 * per-interrupt pend latches and enable masks, reset start-up sequence,
 * APB register slave.
 * assumes peripheral and nmi request pins are asynchronous levels; the
 * fault, call and tick requests come from core logic on the same clock.
 */
// The implementer's own choices: the APB slave port and the register offsets.
// Notes on behaviour
// - ten standard exceptions plus seventeen vectored peripheral inputs.
// - every table slot holds a 32-bit address; all but reserved slots 7 to 10 and 13 are handed to the core.
// - after reset slot 0 is issued as initial stack pointer first.
// - reset uses slot 1, asynchronous, and leaves no activation behind.
// - nmi at slot 2 outranks everything except reset.
// - blocked or disabled faults escalate to hard fault at slot 3.
// - protection-unit mismatch raises memory fault at slot 4.
// - bus fault at slot 5 for prefetch, access and address faults.
// - supervisor call at slot 11 raised when the call instruction executes.
// - debug monitor at slot 12 only when enabled and not halted.
// - pendable service request at slot 14 pended by software only.
// - system tick at slot 15 raised when the tick timer fires.
// - peripheral interrupts occupy slots 16 to 32 in fixed order.
// - reset, nmi, hard fault hold fixed top priorities.
// - other exceptions take 5-bit software priority, lower value wins.
// - equal priority ties go to the lower table position.
// - zero bits written to set, clear or active registers do nothing.
// - enable-set ones enable, enable-clear ones disable an interrupt.
// - pend-set ones set, pend-clear ones clear the pend latch.
// - active register is read-only and shows active interrupts.
// - pend latch gated by enable; later enabling still takes it.
// - request lines are level-sensitive and pend while held.
`timescale 1ns/1ps
`default_nettype none
`include "exc_ctrl_regs.vh"

module top_level_exception_controller
(
   input  wire                    clock,
   input  wire                    rst,
   input  wire                    psel,
   input  wire                    penable,
   input  wire                    pwrite,
   input  wire [11:0]             paddr,
   input  wire [31:0]             pwdata,
   output reg  [31:0]             prdata,
   output reg                     pready,
   output reg                     pslverr,
   input  wire [`IRQ_COUNT-1:0]   irqLines,
   input  wire                    nmiLine,
   input  wire                    memFaultReq,
   input  wire                    busFaultReq,
   input  wire                    usageFaultReq,
   input  wire                    svcReq,
   input  wire                    debugMonReq,
   input  wire                    debugHalted,
   input  wire                    sysTickReq,
   input  wire                    excAck,
   input  wire                    excReturn,
   input  wire [`POS_W-1:0]       excReturnNum,
   output reg                     excReq,
   output reg  [`POS_W-1:0]       excNum,
   output reg  [31:0]             excVector,
   output reg                     spLoad,
   output reg  [31:0]             spValue
);

   reg  [`IRQ_COUNT-1:0]   irqMeta_q;
   reg  [`IRQ_COUNT-1:0]   irqSync_q;
   reg                     nmiMeta_q;
   reg                     nmiSync_q;
   reg  [`IRQ_COUNT-1:0]   enable_q;
   reg  [`EXC_COUNT-1:0]   pend_q;
   reg  [`EXC_COUNT-1:0]   active_q;
   reg  [`CTL_W-1:0]       ctrl_q;
   reg  [`PRI_W-1:0]       pri_q [0:`EXC_LAST];
   reg  [31:0]             vec_q [0:`EXC_LAST];
   reg  [2:0]              state_q;

   reg  [`EXC_COUNT*`KEY_W-1:0] keyVec;
   reg  [`EXC_COUNT-1:0]   setVec;
   reg  [`EXC_COUNT-1:0]   clrVec;
   reg  [`EXC_COUNT-1:0]   actSet;
   reg  [`EXC_COUNT-1:0]   actClr;
   reg  [31:0]             rdData;
   reg                     rdErr;
   integer                 i;
   integer                 k;

   wire                    candFound;
   wire [`POS_W-1:0]       candIdx;
   wire [`KEY_W-1:0]       candKey;
   wire                    actFound;
   wire [`KEY_W-1:0]       actKey;
   wire [`KEY_W-1:0]       curKey;
   wire [`EXC_COUNT-1:0]   candVec;
   wire [`IRQ_COUNT-1:0]   periphReq;
   wire                    escMem;
   wire                    escBus;
   wire                    escUsage;
   wire                    taken;

   // apb decode: answer comes on the second access cycle
   wire                    access = psel & penable;
   wire                    wrDo   = access & pwrite & pready;
   wire [3:0]              region = paddr[11:8];
   wire [`POS_W-1:0]       slot   = paddr[7:2];
   wire                    slotOk = (slot < `EXC_SLOTS);
   wire [`EXC_COUNT-1:0]   priCfgMask = `PRI_CFG_MASK;
   wire                    wePriTbl = wrDo & (region == `REGION_PRI) &
                                      slotOk;
   wire                    weVecTbl = wrDo & (region == `REGION_VEC) &
                                      slotOk;
   wire                    weEnSet  = wrDo & (paddr == `OFF_EN_SET);
   wire                    weEnClr  = wrDo & (paddr == `OFF_EN_CLR);
   wire                    wePndSet = wrDo & (paddr == `OFF_PEND_SET);
   wire                    wePndClr = wrDo & (paddr == `OFF_PEND_CLR);
   wire                    weCtrl   = wrDo & (paddr == `OFF_SYS_CTRL);

   // pins are asynchronous: two flops before anything looks at them
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         irqMeta_q <= {`IRQ_COUNT{1'b0}};
         irqSync_q <= {`IRQ_COUNT{1'b0}};
         nmiMeta_q <= 1'b0;
         nmiSync_q <= 1'b0;
      end
      else
      begin
         irqMeta_q <= irqLines;
         irqSync_q <= irqMeta_q;
         nmiMeta_q <= nmiLine;
         nmiSync_q <= nmiMeta_q;
      end
   end

   // priority keys per slot
   always @*
   begin
      keyVec = {`EXC_COUNT*`KEY_W{1'b0}};
      for (i = 0; i < `EXC_COUNT; i = i + 1)
      begin
         if (i == `POS_NMI)
            keyVec[i*`KEY_W +: `KEY_W] = `KEY_NMI;
         else if (i == `POS_HARD)
            keyVec[i*`KEY_W +: `KEY_W] = `KEY_HARD;
         else
            keyVec[i*`KEY_W +: `KEY_W] =
               {1'b0, pri_q[i]} + `KEY_BIAS;
      end
   end

   // level lines pend while held; mask gates latch and line alike
   assign periphReq = (pend_q[`EXC_LAST:`IRQ_BASE] | irqSync_q) &
                      enable_q;
   // a fault about to escalate is never offered in its own slot
   assign candVec   = {periphReq, pend_q[`POS_SYSTEM_TICK_EXCEPTION:`POS_HARD],
                       nmiSync_q, 2'b00} & ~active_q &
                      ~{{(`EXC_COUNT-`POS_USAGE-1){1'b0}}, escUsage,
                        escBus, escMem, 4'h0};

   exc_priority_select candSel
   (
      .req   (candVec),
      .keys  (keyVec),
      .found (candFound),
      .idx   (candIdx),
      .key   (candKey)
   );

   exc_priority_select actSel
   (
      .req   (active_q),
      .keys  (keyVec),
      .found (actFound),
      .idx   (),
      .key   (actKey)
   );

   assign curKey = actFound ? actKey : `KEY_IDLE;

   // a fault that is disabled or cannot preempt becomes a hard fault
   assign escMem   = pend_q[`POS_MEM] & (~ctrl_q[`CTL_MEM_EN] |
                     (keyVec[`POS_MEM*`KEY_W +: `KEY_W] >= curKey));
   assign escBus   = pend_q[`POS_BUS] & (~ctrl_q[`CTL_BUS_EN] |
                     (keyVec[`POS_BUS*`KEY_W +: `KEY_W] >= curKey));
   assign escUsage = pend_q[`POS_USAGE] & (~ctrl_q[`CTL_USAGE_EN] |
                     (keyVec[`POS_USAGE*`KEY_W +: `KEY_W] >= curKey));

   assign taken = excAck & excReq & (state_q == `ST_RUN);

   // pend sources; sets are applied after clears so a new event survives
   always @*
   begin
      setVec = {`EXC_COUNT{1'b0}};
      clrVec = {`EXC_COUNT{1'b0}};
      setVec[`POS_MEM]     = memFaultReq;
      setVec[`POS_BUS]     = busFaultReq;
      setVec[`POS_USAGE]   = usageFaultReq;
      setVec[`POS_SVC]     = svcReq;
      setVec[`POS_DBGMON]  = debugMonReq & ctrl_q[`CTL_DBGMON_EN] &
                             ~debugHalted;
      setVec[`POS_PENDABLE_SERVICE_REQUEST]  = weCtrl & pwdata[`CTL_PENDABLE_SERVICE_REQUEST_SET];
      setVec[`POS_SYSTEM_TICK_EXCEPTION] = sysTickReq;
      setVec[`POS_HARD]    = escMem | escBus | escUsage;
      clrVec[`POS_MEM]     = escMem;
      clrVec[`POS_BUS]     = escBus;
      clrVec[`POS_USAGE]   = escUsage;
      clrVec[`POS_PENDABLE_SERVICE_REQUEST]  = weCtrl & pwdata[`CTL_PENDABLE_SERVICE_REQUEST_CLR];
      if (wePndSet)
         setVec[`EXC_LAST:`IRQ_BASE] = pwdata[`IRQ_TOP:0];
      if (wePndClr)
         clrVec[`EXC_LAST:`IRQ_BASE] = pwdata[`IRQ_TOP:0];
      if (taken)
         clrVec = clrVec | ({{(`EXC_COUNT-1){1'b0}}, 1'b1} << excNum);
      actSet = {`EXC_COUNT{1'b0}};
      actClr = {`EXC_COUNT{1'b0}};
      if (taken)
         actSet = {{(`EXC_COUNT-1){1'b0}}, 1'b1} << excNum;
      if (excReturn)
         actClr = {{(`EXC_COUNT-1){1'b0}}, 1'b1} << excReturnNum;
   end

   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         enable_q <= {`IRQ_COUNT{1'b0}};
         pend_q   <= {`EXC_COUNT{1'b0}};
         active_q <= {`EXC_COUNT{1'b0}};
         ctrl_q   <= `CTL_RESET;
         for (k = 0; k < `EXC_COUNT; k = k + 1)
         begin
            pri_q[k] <= {`PRI_W{1'b0}};
            vec_q[k] <= 32'h0000_0000;
         end
      end
      else
      begin
         enable_q <= (enable_q & ~({`IRQ_COUNT{weEnClr}} &
                     pwdata[`IRQ_TOP:0])) |
                     ({`IRQ_COUNT{weEnSet}} & pwdata[`IRQ_TOP:0]);
         pend_q   <= ((pend_q & ~clrVec) | setVec) & `PEND_IMPL_MASK;
         active_q <= (active_q & ~actClr) | actSet;
         if (weCtrl)
            ctrl_q <= pwdata[`CTL_W-1:0];
         if (wePriTbl && priCfgMask[slot])
            pri_q[slot] <= pwdata[`PRI_W-1:0];
         if (weVecTbl)
            vec_q[slot] <= pwdata;
      end
   end

   // read mux; unmapped addresses answer with pslverr and zero
   always @*
   begin
      rdData = 32'h0000_0000;
      rdErr  = 1'b0;
      if (region == `REGION_PRI && slotOk)
         rdData[`PRI_W-1:0] = pri_q[slot];
      else if (region == `REGION_VEC && slotOk)
         rdData = vec_q[slot];
      else
      begin
         case (paddr)
            `OFF_EN_SET,
            `OFF_EN_CLR:   rdData[`IRQ_TOP:0] = enable_q;
            `OFF_PEND_SET,
            `OFF_PEND_CLR: rdData[`IRQ_TOP:0] = pend_q[`EXC_LAST:`IRQ_BASE];
            `OFF_ACTIVE:   rdData[`IRQ_TOP:0] =
                              active_q[`EXC_LAST:`IRQ_BASE];
            `OFF_SYS_CTRL:
            begin
               rdData[`CTL_W-1:0] = ctrl_q;
               rdData[`CTL_PENDABLE_SERVICE_REQUEST_SET] = pend_q[`POS_PENDABLE_SERVICE_REQUEST];
            end
            `OFF_CUR_PRI:  rdData[`KEY_W-1:0] = curKey;
            default:       rdErr = 1'b1;
         endcase
      end
   end

   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= access & ~pready;
         pslverr <= access & ~pready & rdErr;
         if (access && !pready && !pwrite)
            prdata <= rdData;
      end
   end

   // start-up: stack pointer, then reset vector, then normal arbitration
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_q   <= `ST_SP;
         excReq    <= 1'b0;
         excNum    <= `POS_SP;
         excVector <= 32'h0000_0000;
         spLoad    <= 1'b0;
         spValue   <= 32'h0000_0000;
      end
      else
      begin
         case (state_q)
            `ST_SP:
            begin
               spLoad  <= 1'b1;
               spValue <= vec_q[`POS_SP];
               state_q <= `ST_RV;
            end
            `ST_RV:
            begin
               spLoad    <= 1'b0;
               excReq    <= 1'b1;
               excNum    <= `POS_RESET;
               excVector <= vec_q[`POS_RESET];
               // no active bit is kept: the handler runs as thread level
               if (excAck && excReq)
               begin
                  excReq  <= 1'b0;
                  state_q <= `ST_RUN;
               end
            end
            `ST_RUN:
            begin
               spLoad <= 1'b0;
               // drop for a cycle after an ack so the taken slot is not
               // offered again before its active bit lands
               if (taken)
                  excReq <= 1'b0;
               else
               begin
                  excReq    <= candFound & (candKey < curKey);
                  excNum    <= candIdx;
                  excVector <= vec_q[candIdx];
               end
            end
            default:
               state_q <= `ST_SP;
         endcase
      end
   end

endmodule
`default_nettype wire

// ### testbench/core_model.sv
/* behavioural core: acks offered exceptions, returns them on request
   assumes the controller handshake on the shared clock */
`timescale 1ns/1ps
`default_nettype none
module core_model
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        excReq,
   input  wire logic [5:0]  excNum,
   input  wire logic [31:0] excVector,
   input  wire logic        ackEn,
   input  wire logic        retEn,
   input  wire logic [3:0]  ackDelay,
   output var  logic        excAck,
   output var  logic        excReturn,
   output var  logic [5:0]  excReturnNum,
   output var  logic [5:0]  lastNum,
   output var  logic [31:0] lastVec,
   output var  logic [7:0]  takes
);
   logic [3:0] cnt_q;
   logic       busy_q;
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         {excAck, excReturn, excReturnNum, cnt_q, busy_q} <= '0;
         {lastNum, lastVec, takes} <= '0;
      end
      else
      begin
         excAck <= 1'b0;
         excReturn <= 1'b0;
         // number means nothing between returns, so keep it moving
         excReturnNum <= excReturnNum + 6'h1;
         if (excAck && excReq)
         begin
            lastNum <= excNum;
            lastVec <= excVector;
            takes <= takes + 8'h1;
            cnt_q <= 4'h0;
            busy_q <= (excNum != 6'h1);
         end
         else if (ackEn && excReq && cnt_q >= ackDelay)
            excAck <= 1'b1;
         else if (ackEn && excReq)
            cnt_q <= cnt_q + 4'h1;
         if (retEn && busy_q && !excAck)
         begin
            excReturn <= 1'b1;
            excReturnNum <= lastNum;
            busy_q <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### testbench/exc_ctrl_asserts.sv
/* port checker for the exception controller
   assumes one clock and an active-high asynchronous reset */
`timescale 1ns/1ps
`default_nettype none
module exc_ctrl_checker
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   input wire logic        nmiLine,
   input wire logic        excAck,
   input wire logic        excReq,
   input wire logic [5:0]  excNum,
   input wire logic        spLoad
);
   logic spSeen_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // stack load must happen once per reset, never on later traffic
   always @(posedge clock or posedge rst)
      if (rst)
         spSeen_q <= 1'b0;
      else if (spLoad)
         spSeen_q <= 1'b1;
   apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("apb answer not on second access edge");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
      else $error("refused read not zero");
   start_seq_a: assert property (spLoad |=> !spLoad && excReq && excNum == 6'h1)
      else $error("reset vector not offered after stack load");
   sp_once_a: assert property (spLoad |-> !spSeen_q)
      else $error("second stack load");
   ack_drop_a: assert property (excAck && excReq |=> !excReq)
      else $error("offer held after ack");
   slot_legal_a: assert property (excReq |-> excNum inside {[6'h1:6'h6], 6'hb, 6'hc, [6'he:6'h20]})
      else $error("offer on reserved slot");
   nmi_first_a: assert property (nmiLine [*5] |-> !excReq || excNum <= 6'h2)
      else $error("lower exception offered over nmi");
   cover property (pready && pslverr);
   cover property (excAck && excReq && excNum == 6'h3);
   cover property (excAck && excReq && excNum == 6'h20);
endmodule
bind top_level_exception_controller exc_ctrl_checker chk_u
(
   .clock(clock), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .nmiLine(nmiLine), .excAck(excAck), .excReq(excReq), .excNum(excNum),
   .spLoad(spLoad)
);
`default_nettype wire

// ### testbench/tb_top_level_exception_controller.sv
/* self-checking bench for the exception controller
   assumes core_model and the checker are compiled first */
`timescale 1ns/1ps
`default_nettype none
`include "exc_ctrl_regs.vh"
module tb_top_level_exception_controller;
   typedef struct {logic [5:0] ctl; logic [6:0] pul; logic [16:0] irq;
      logic [5:0] slot;} row_t;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [16:0] irqLines = 17'h0;
   logic [5:0]  pulses = 6'h0;
   logic        nmiLine = 1'b0;
   logic        debugHalted = 1'b0;
   logic        ackEn = 1'b0;
   logic        retEn = 1'b0;
   logic [3:0]  ackDelay = 4'h0;
   wire  [31:0] prdata, excVector, spValue, lastVec;
   wire         pready, pslverr, excReq, spLoad, excAck, excReturn;
   wire  [5:0]  excNum, excReturnNum, lastNum;
   wire  [7:0]  takes;
   logic [7:0]  seen = 8'h0;
   logic [31:0] rdat;
   logic        rerr;
   int          fails = 0;
   int          samplesChecked = 0;
   int          i;
   int          j;
   row_t        rows [27];

   top_level_exception_controller dut_u
   (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irqLines(irqLines),
      .nmiLine(nmiLine), .memFaultReq(pulses[0]), .busFaultReq(pulses[1]),
      .usageFaultReq(pulses[2]), .svcReq(pulses[3]),
      .debugMonReq(pulses[4]), .debugHalted(debugHalted),
      .sysTickReq(pulses[5]), .excAck(excAck), .excReturn(excReturn),
      .excReturnNum(excReturnNum), .excReq(excReq), .excNum(excNum),
      .excVector(excVector), .spLoad(spLoad), .spValue(spValue)
   );
   core_model core_u
   (
      .clock(clock), .rst(rst), .excReq(excReq), .excNum(excNum),
      .excVector(excVector), .ackEn(ackEn), .retEn(retEn),
      .ackDelay(ackDelay), .excAck(excAck), .excReturn(excReturn),
      .excReturnNum(excReturnNum), .lastNum(lastNum), .lastVec(lastVec),
      .takes(takes)
   );

   always #2 clock = ~clock;

   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 40);
      if (pready !== 1'b1)
      begin
         fails++;
         giveVerdict();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdat, exp);
   endtask

   // vectors are written as 0x5a000000 plus the slot number
   task automatic take(input logic [5:0] s);
      int n;
      n = 0;
      while (takes === seen && n < 60)
      begin
         @(posedge clock);
         n++;
      end
      if (takes === seen)
      begin
         fails++;
         giveVerdict();
      end
      seen = takes;
      check({26'h0, lastNum}, {26'h0, s});
      check(lastVec, 32'h5a00_0000 | {26'h0, s});
   endtask

   initial
   begin
      rows[0] = '{6'h00, 7'h01, 17'h0, 6'h03};
      rows[1] = '{6'h01, 7'h01, 17'h0, 6'h04};
      rows[2] = '{6'h02, 7'h02, 17'h0, 6'h05};
      rows[3] = '{6'h04, 7'h04, 17'h0, 6'h06};
      rows[4] = '{6'h00, 7'h08, 17'h0, 6'h0b};
      rows[5] = '{6'h08, 7'h10, 17'h0, 6'h0c};
      rows[6] = '{6'h00, 7'h10, 17'h0, 6'h00};
      rows[7] = '{6'h10, 7'h00, 17'h0, 6'h0e};
      rows[8] = '{6'h00, 7'h20, 17'h0, 6'h0f};
      rows[9] = '{6'h00, 7'h40, 17'h0, 6'h02};
      for (int n = 0; n < 17; n++)
         rows[10 + n] = '{6'h00, 7'h00, 17'h1 << n, 6'(16 + n)};
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      check({30'h0, spLoad, excReq}, 32'h2);
      check(spValue, 32'h0);
      @(posedge clock);
      check({24'h0, spLoad, excReq, excNum}, 32'h41);
      check(excVector, 32'h0);
      rdc(`OFF_CUR_PRI, 32'h3f);
      for (j = 1; j < 33; j++)
         wr(12'h200 + 12'(4 * j), 32'h5a00_0000 | 32'(j));
      ackEn <= 1'b1;
      take(6'h1);
      $display("reset test done");
      ackEn <= 1'b0;
      wr(`OFF_EN_SET, 32'h0001_ffff);
      rdc(`OFF_EN_SET, 32'h0001_ffff);
      wr(`OFF_EN_CLR, 32'h0001_fffe);
      wr(`OFF_EN_SET, 32'h0);
      rdc(`OFF_EN_CLR, 32'h1);
      wr(`OFF_PEND_SET, 32'h6);
      wr(`OFF_PEND_CLR, 32'h4);
      wr(`OFF_PEND_CLR, 32'h0);
      rdc(`OFF_PEND_SET, 32'h2);
      check({31'h0, excReq}, 32'h0);
      ackEn <= 1'b1;
      wr(`OFF_EN_SET, 32'h2);
      take(6'h11);
      wr(`OFF_ACTIVE, 32'hffff_fffd);
      rdc(`OFF_ACTIVE, 32'h2);
      rdc(`OFF_PEND_SET, 32'h0);
      retEn <= 1'b1;
      rdc(`OFF_ACTIVE, 32'h0);
      apb(1'b0, 12'hffc, 32'h0);
      check({31'h0, rerr}, 32'h1);
      wr(12'h108, 32'h5);
      rdc(12'h108, 32'h0);
      $display("register test done");
      wr(`OFF_EN_SET, 32'h0001_ffff);
      for (i = 0; i < 27; i++)
      begin
         retEn <= 1'b0;
         ackDelay <= 4'(i % 4);
         wr(`OFF_SYS_CTRL, {26'h0, rows[i].ctl});
         @(posedge clock);
         pulses <= rows[i].pul[5:0];
         {nmiLine, irqLines} <= {rows[i].pul[6], rows[i].irq};
         @(posedge clock);
         pulses <= 6'h0;
         if (rows[i].slot != 6'h0)
            take(rows[i].slot);
         else
         begin
            repeat (12) @(posedge clock);
            check({24'h0, takes}, {24'h0, seen});
         end
         {nmiLine, irqLines} <= 18'h0;
         repeat (4) @(posedge clock);
         wr(`OFF_PEND_CLR, 32'h0001_ffff);
         retEn <= 1'b1;
         repeat (6) @(posedge clock);
         seen = takes;
         $display("row %0d done", i);
      end
      ackDelay <= 4'h0;
      for (j = 0; j < 2; j++)
      begin
         ackEn <= 1'b0;
         wr(12'h170, (j == 1) ? 32'h7 : 32'h5);
         wr(12'h174, (j == 1) ? 32'h3 : 32'h5);
         wr(`OFF_PEND_SET, 32'h3000);
         ackEn <= 1'b1;
         take((j == 1) ? 6'h1d : 6'h1c);
         take((j == 1) ? 6'h1c : 6'h1d);
      end
      $display("tie test done");
      debugHalted <= 1'b1;
      wr(`OFF_SYS_CTRL, 32'h8);
      pulses <= 6'h10;
      @(posedge clock);
      pulses <= 6'h0;
      repeat (12) @(posedge clock);
      check({24'h0, takes}, {24'h0, seen});
      debugHalted <= 1'b0;
      $display("halt test done");
      retEn <= 1'b0;
      ackEn <= 1'b0;
      nmiLine <= 1'b1;
      wr(`OFF_PEND_SET, 32'h1);
      ackEn <= 1'b1;
      take(6'h2);
      nmiLine <= 1'b0;
      rdc(`OFF_CUR_PRI, 32'h0);
      retEn <= 1'b1;
      take(6'h10);
      $display("nmi test done");
      giveVerdict();
   end
endmodule
`default_nettype wire
